// file: hw/jtpc_pkg.sv
//------------------------------------------------------------------------------
// Summary of operation
// - Test data input is shifted into the selected register on test clock rising edges.
// - Mode select and data inputs are sampled only on test clock rising edges.
// - Test data output changes only on test clock falling edges, and clears while test reset is low.
// - With test reset high, the test port controls the device.
// - With test reset low or open, normal mode runs and port inputs are ignored.
// - Event pin 1 is bidirectional; emulation logic sets its direction.
// - Software pull-inhibit controls switch pull-ups on data input, clock, mode select, select pin and event pin 1.
// - Test reset carries an internal pull-down, so open means functional mode.
// - Test data output is high impedance except while a scan is shifting.
// - On test reset low-then-high, latch the select pin to choose scan or emulation port.
//------------------------------------------------------------------------------
package jtpc_pkg;

  // Instruction register
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // Identification value is arbitrary; the low bit must be one
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_1001;

  // Synchroniser lane positions
  localparam int SYNC_STAGES = 2;
  localparam int LANES = 6;
  localparam int L_TCK = 0;
  localparam int L_TMS = 1;
  localparam int L_TDI = 2;
  localparam int L_TRST = 3;
  localparam int L_TAP_SELECT_PIN = 4;
  localparam int L_EMULATOR_EVENT_PIN_1 = 5;

  // Pull-inhibit control bit positions
  localparam int PI_W = 5;
  localparam int PI_TDI = 0;
  localparam int PI_TCK = 1;
  localparam int PI_TMS = 2;
  localparam int PI_TAP_SELECT_PIN = 3;
  localparam int PI_EMULATOR_EVENT_PIN_1 = 4;

  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtpc_state_e;

endpackage : jtpc_pkg

// file: hw/jtpc_sync.sv
`timescale 1ns/1ps
module jtpc_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
) (
  input wire logic core_clk, // Sampling clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [W-1:0] async_in, // Lanes from outside the domain
  output logic [W-1:0] sync_out // Lanes after the last stage
);

  logic [W-1:0] stage [STAGES];

  // Only the next stage reads each stage; reset clears to low
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_out = stage[STAGES-1];

endmodule : jtpc_sync

// file: hw/jtpc_top.sv
`timescale 1ns/1ps
module jtpc_top #(
  parameter int IR_W = jtpc_pkg::IR_W,
  parameter int ID_W = jtpc_pkg::ID_W,
  parameter logic [jtpc_pkg::ID_W-1:0] ID_VALUE = jtpc_pkg::ID_VALUE
) (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic tck_pin, // Test clock pin
  input wire logic tms_pin, // Test mode select pin
  input wire logic tdi_pin, // Test data input pin
  input wire logic trst_b_pin, // Test reset pin, active low
  output logic tdo_o, // Test data output value
  output logic tdo_oe, // Test data output enable
  input wire logic tap_select_pin_i, // Select pin level
  output logic tap_select_pin_o, // Select pin drive value
  output logic tap_select_pin_oe, // Select pin drive enable
  input wire logic emulator_event_pin_1_i, // Event pin 1 level
  output logic emulator_event_pin_1_o, // Event pin 1 drive value
  output logic emulator_event_pin_1_oe, // Event pin 1 drive enable
  input wire logic tap_select_pin_drive, // Emulation logic value for select pin
  input wire logic tap_select_pin_dir_out, // Emulation logic wants select pin as output
  input wire logic emulator_event_pin_1_drive, // Emulation logic value for event pin 1
  input wire logic emulator_event_pin_1_dir_out, // Emulation logic wants event pin 1 as output
  output logic tap_select_pin_event, // Synchronised select pin event to core
  output logic emulator_event_pin_1_event, // Synchronised event pin 1 to core
  input wire logic [jtpc_pkg::PI_W-1:0] pull_inhibit_reg_2, // Pull-up inhibit controls
  output logic [jtpc_pkg::PI_W-1:0] internal_pullup_en, // Pull-up enables
  output logic internal_pulldown_en, // Pull-down enable on test reset
  output logic test_mode, // Test port owns the device
  output logic tap_sel, // Latched select: 0 scan, 1 emulation
  output logic [IR_W-1:0] ir_value // Active instruction
);

  //----------------------------------------------------------------------------
  // Pin sampling
  //----------------------------------------------------------------------------
  logic [jtpc_pkg::LANES-1:0] pins_raw;
  logic [jtpc_pkg::LANES-1:0] pins_s;
  logic tck_d;
  logic trst_d;
  logic tck_rise;
  logic tck_fall;
  logic trst_rise;

  assign pins_raw[jtpc_pkg::L_TCK] = tck_pin;
  assign pins_raw[jtpc_pkg::L_TMS] = tms_pin;
  assign pins_raw[jtpc_pkg::L_TDI] = tdi_pin;
  assign pins_raw[jtpc_pkg::L_TRST] = trst_b_pin;
  assign pins_raw[jtpc_pkg::L_TAP_SELECT_PIN] = tap_select_pin_i;
  assign pins_raw[jtpc_pkg::L_EMULATOR_EVENT_PIN_1] = emulator_event_pin_1_i;

  jtpc_sync #(
    .W(jtpc_pkg::LANES),
    .STAGES(jtpc_pkg::SYNC_STAGES)
  ) i_jtpc_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tck_d <= 1'b0;
      trst_d <= 1'b0;
    end else begin
      tck_d <= pins_s[jtpc_pkg::L_TCK];
      trst_d <= pins_s[jtpc_pkg::L_TRST];
    end
  end

  assign tck_rise = pins_s[jtpc_pkg::L_TCK] & ~tck_d;
  assign tck_fall = ~pins_s[jtpc_pkg::L_TCK] & tck_d;
  assign trst_rise = pins_s[jtpc_pkg::L_TRST] & ~trst_d;

  // Open pin reads low through the pull-down, so functional mode holds
  assign test_mode = pins_s[jtpc_pkg::L_TRST];
  assign internal_pulldown_en = 1'b1;

  //----------------------------------------------------------------------------
  // Pull-up control
  //----------------------------------------------------------------------------
  assign internal_pullup_en = ~pull_inhibit_reg_2;

  //----------------------------------------------------------------------------
  // Controller
  //----------------------------------------------------------------------------
  jtpc_pkg::jtpc_state_e state;
  jtpc_pkg::jtpc_state_e next_state;

  function automatic jtpc_pkg::jtpc_state_e step(input jtpc_pkg::jtpc_state_e s,
                                                 input logic tms);
    case (s)
      jtpc_pkg::ST_RESET: step = tms ? jtpc_pkg::ST_RESET : jtpc_pkg::ST_IDLE;
      jtpc_pkg::ST_IDLE: step = tms ? jtpc_pkg::ST_SEL_DR : jtpc_pkg::ST_IDLE;
      jtpc_pkg::ST_SEL_DR: step = tms ? jtpc_pkg::ST_SEL_IR : jtpc_pkg::ST_CAP_DR;
      jtpc_pkg::ST_CAP_DR: step = tms ? jtpc_pkg::ST_EX1_DR : jtpc_pkg::ST_SH_DR;
      jtpc_pkg::ST_SH_DR: step = tms ? jtpc_pkg::ST_EX1_DR : jtpc_pkg::ST_SH_DR;
      jtpc_pkg::ST_EX1_DR: step = tms ? jtpc_pkg::ST_UPD_DR : jtpc_pkg::ST_PAU_DR;
      jtpc_pkg::ST_PAU_DR: step = tms ? jtpc_pkg::ST_EX2_DR : jtpc_pkg::ST_PAU_DR;
      jtpc_pkg::ST_EX2_DR: step = tms ? jtpc_pkg::ST_UPD_DR : jtpc_pkg::ST_SH_DR;
      jtpc_pkg::ST_UPD_DR: step = tms ? jtpc_pkg::ST_SEL_DR : jtpc_pkg::ST_IDLE;
      jtpc_pkg::ST_SEL_IR: step = tms ? jtpc_pkg::ST_RESET : jtpc_pkg::ST_CAP_IR;
      jtpc_pkg::ST_CAP_IR: step = tms ? jtpc_pkg::ST_EX1_IR : jtpc_pkg::ST_SH_IR;
      jtpc_pkg::ST_SH_IR: step = tms ? jtpc_pkg::ST_EX1_IR : jtpc_pkg::ST_SH_IR;
      jtpc_pkg::ST_EX1_IR: step = tms ? jtpc_pkg::ST_UPD_IR : jtpc_pkg::ST_PAU_IR;
      jtpc_pkg::ST_PAU_IR: step = tms ? jtpc_pkg::ST_EX2_IR : jtpc_pkg::ST_PAU_IR;
      jtpc_pkg::ST_EX2_IR: step = tms ? jtpc_pkg::ST_UPD_IR : jtpc_pkg::ST_SH_IR;
      jtpc_pkg::ST_UPD_IR: step = tms ? jtpc_pkg::ST_SEL_DR : jtpc_pkg::ST_IDLE;
      default: step = jtpc_pkg::ST_RESET;
    endcase
  endfunction : step

  assign next_state = step(state, pins_s[jtpc_pkg::L_TMS]);

  // Low test reset forces reset state on the next core clock edge once synchronised, whatever the test clock does
  always_ff @(posedge core_clk) begin
    if (!rst_b || !test_mode) begin
      state <= jtpc_pkg::ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  //----------------------------------------------------------------------------
  // Instruction register
  //----------------------------------------------------------------------------
  logic [IR_W-1:0] ir_shift;

  always_ff @(posedge core_clk) begin
    if (!rst_b || !test_mode) begin
      ir_shift <= jtpc_pkg::IR_CAPTURE;
      ir_value <= jtpc_pkg::IR_IDCODE;
    end else if (tck_rise) begin
      case (state)
        jtpc_pkg::ST_RESET: begin
          ir_value <= jtpc_pkg::IR_IDCODE;
        end
        jtpc_pkg::ST_CAP_IR: begin
          ir_shift <= jtpc_pkg::IR_CAPTURE;
        end
        jtpc_pkg::ST_SH_IR: begin
          ir_shift <= {pins_s[jtpc_pkg::L_TDI], ir_shift[IR_W-1:1]};
        end
        jtpc_pkg::ST_UPD_IR: begin
          ir_value <= ir_shift;
        end
        default: begin
          ir_value <= ir_value;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Data registers
  //----------------------------------------------------------------------------
  logic bypass_reg;
  logic [ID_W-1:0] id_shift;
  logic sel_id;

  assign sel_id = (ir_value == jtpc_pkg::IR_IDCODE);

  always_ff @(posedge core_clk) begin
    if (!rst_b || !test_mode) begin
      bypass_reg <= 1'b0;
      id_shift <= ID_VALUE;
    end else if (tck_rise) begin
      case (state)
        jtpc_pkg::ST_CAP_DR: begin
          bypass_reg <= 1'b0;
          id_shift <= ID_VALUE;
        end
        jtpc_pkg::ST_SH_DR: begin
          if (sel_id) begin
            id_shift <= {pins_s[jtpc_pkg::L_TDI], id_shift[ID_W-1:1]};
          end else begin
            bypass_reg <= pins_s[jtpc_pkg::L_TDI];
          end
        end
        default: begin
          bypass_reg <= bypass_reg;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Test data output
  //----------------------------------------------------------------------------
  // Value and enable move together on the falling edge, giving a half period
  // of setup before the tester samples on the next rising edge
  always_ff @(posedge core_clk) begin
    if (!rst_b || !test_mode) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (state == jtpc_pkg::ST_SH_IR) || (state == jtpc_pkg::ST_SH_DR);
      if (state == jtpc_pkg::ST_SH_IR) begin
        tdo_o <= ir_shift[0];
      end else if (sel_id) begin
        tdo_o <= id_shift[0];
      end else begin
        tdo_o <= bypass_reg;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Port selection and emulation event pins
  //----------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tap_sel <= 1'b0;
    end else if (trst_rise) begin
      tap_sel <= pins_s[jtpc_pkg::L_TAP_SELECT_PIN];
    end
  end

  // Pins drive only in test mode; in functional mode the core sees nothing
  assign emulator_event_pin_1_o = emulator_event_pin_1_drive;
  assign emulator_event_pin_1_oe = test_mode & emulator_event_pin_1_dir_out;
  assign tap_select_pin_o = tap_select_pin_drive;
  assign tap_select_pin_oe = test_mode & tap_select_pin_dir_out;

  always_ff @(posedge core_clk) begin
    if (!rst_b || !test_mode) begin
      emulator_event_pin_1_event <= 1'b0;
      tap_select_pin_event <= 1'b0;
    end else begin
      emulator_event_pin_1_event <= pins_s[jtpc_pkg::L_EMULATOR_EVENT_PIN_1] & ~emulator_event_pin_1_dir_out;
      tap_select_pin_event <= pins_s[jtpc_pkg::L_TAP_SELECT_PIN] & ~tap_select_pin_dir_out;
    end
  end

endmodule : jtpc_top

// file: tb/jtpc_top_sva.sv
`timescale 1ns/1ps
module jtpc_top_sva #(
  parameter int IR_W = 4
) (
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic tck_pin, // Test clock
  input wire logic tdo_o, // Data out
  input wire logic tdo_oe, // Data out enable
  input wire logic tap_select_pin_oe, // Select enable
  input wire logic emulator_event_pin_1_o, // Event value
  input wire logic emulator_event_pin_1_oe, // Event enable
  input wire logic tap_select_pin_dir_out, // Select direction
  input wire logic emulator_event_pin_1_drive, // Event drive
  input wire logic emulator_event_pin_1_dir_out, // Event direction
  input wire logic tap_select_pin_event, // Select event
  input wire logic emulator_event_pin_1_event, // Event 1
  input wire logic [jtpc_pkg::PI_W-1:0] pull_inhibit_reg_2, // Inhibits
  input wire logic [jtpc_pkg::PI_W-1:0] internal_pullup_en, // Pull-ups
  input wire logic internal_pulldown_en, // Pull-down
  input wire logic test_mode, // Test owns device
  input wire logic tap_sel, // Latched select
  input wire logic [IR_W-1:0] ir_value // Instruction
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_pullup_inv: assert property (internal_pullup_en == ~pull_inhibit_reg_2)
    else $error("pull-up enables wrong");
  chk_pulldown_on: assert property (internal_pulldown_en)
    else $error("pull-down off");
  chk_evt1_dir: assert property (emulator_event_pin_1_oe == (test_mode && emulator_event_pin_1_dir_out))
    else $error("event pin enable wrong");
  chk_evt1_val: assert property (emulator_event_pin_1_oe |-> emulator_event_pin_1_o == emulator_event_pin_1_drive)
    else $error("event pin value wrong");
  chk_sel_dir: assert property (tap_select_pin_oe == (test_mode && tap_select_pin_dir_out))
    else $error("select pin enable wrong");
  chk_evt_quiet: assert property (!test_mode [*3] |-> !tap_select_pin_event && !emulator_event_pin_1_event)
    else $error("event seen in functional mode");
  chk_tdo_func: assert property (!test_mode [*3] |-> !tdo_oe)
    else $error("data out driven in functional mode");
  chk_tlr_ir: assert property (!test_mode [*3] |-> ir_value == jtpc_pkg::IR_IDCODE)
    else $error("instruction not reset");
  // Changes are three or four edges after the sampled fall
  chk_tdo_fall: assert property (test_mode && $past(test_mode) &&
      (($changed(tdo_o) && tdo_oe) || $changed(tdo_oe))
      |-> !$past(tck_pin, 3) && !$past(tck_pin, 2))
    else $error("data out changed off a falling edge");
  chk_sel_latch: assert property ($changed(tap_sel)
      |-> test_mode && (!$past(test_mode, 2) || !$past(test_mode, 3)))
    else $error("select latched outside reset release");
  cov_tdo_on: cover property ($rose(tdo_oe));
  cov_sel_one: cover property ($rose(tap_sel));
  cov_evt: cover property ($rose(emulator_event_pin_1_event));
endmodule : jtpc_top_sva
bind jtpc_top jtpc_top_sva #(.IR_W(IR_W)) i_jtpc_top_sva (.core_clk(core_clk), .rst_b(rst_b),
  .tck_pin(tck_pin), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tap_select_pin_oe(tap_select_pin_oe),
  .emulator_event_pin_1_o(emulator_event_pin_1_o),
  .emulator_event_pin_1_oe(emulator_event_pin_1_oe), .tap_select_pin_dir_out(tap_select_pin_dir_out),
  .emulator_event_pin_1_drive(emulator_event_pin_1_drive), .emulator_event_pin_1_dir_out(emulator_event_pin_1_dir_out), .tap_select_pin_event(tap_select_pin_event),
  .emulator_event_pin_1_event(emulator_event_pin_1_event), .pull_inhibit_reg_2(pull_inhibit_reg_2),
  .internal_pullup_en(internal_pullup_en), .internal_pulldown_en(internal_pulldown_en),
  .test_mode(test_mode), .tap_sel(tap_sel), .ir_value(ir_value));

// file: tb/jtpc_tester.sv
`timescale 1ns/1ps
module jtpc_tester (
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Data in
  output logic trst_b, // Test reset
  input wire logic tdo_o, // Data out value
  input wire logic tdo_oe // Data out enable
);
  // ---------------------------------------------
  // Probe side
  // ---------------------------------------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_b = 1'b0;
  end
  // Balanced halves; clock rests low between frames
  task automatic bit_step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdo_oe ? tdo_o : 1'bz; // Released line must not pass as data
    #62.5 tck = 1'b0;
  endtask : bit_step
  task automatic set_trst(input logic v);
    trst_b = v;
  endtask : set_trst
endmodule : jtpc_tester

// file: tb/jtpc_tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, got, exp); end end
module jtpc_tb_top;
  logic core_clk, rst_b, tck, tms, tdi, trst_b, tdo_o, tdo_oe, sel_o, sel_oe, evt_o, evt_oe;
  logic e0_drv, e0_dir, e1_drv, e1_dir, e0_ev, e1_ev, pd_en, test_mode, tap_sel, sel_drv, evt_drv;
  logic [jtpc_pkg::PI_W-1:0] pi, pu_en;
  logic [jtpc_pkg::IR_W-1:0] ir_value;
  logic [63:0] din, dout;
  wire sel_wire = sel_oe ? sel_o : sel_drv;
  wire evt_wire = evt_oe ? evt_o : evt_drv;
  int mismatches, cmp_count;
  jtpc_top i_jtpc_top (.core_clk(core_clk), .rst_b(rst_b), .tck_pin(tck), .tms_pin(tms),
    .tdi_pin(tdi), .trst_b_pin(trst_b), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .tap_select_pin_i(sel_wire), .tap_select_pin_o(sel_o), .tap_select_pin_oe(sel_oe),
    .emulator_event_pin_1_i(evt_wire), .emulator_event_pin_1_o(evt_o),
    .emulator_event_pin_1_oe(evt_oe), .tap_select_pin_drive(e0_drv), .tap_select_pin_dir_out(e0_dir),
    .emulator_event_pin_1_drive(e1_drv), .emulator_event_pin_1_dir_out(e1_dir), .tap_select_pin_event(e0_ev), .emulator_event_pin_1_event(e1_ev),
    .pull_inhibit_reg_2(pi), .internal_pullup_en(pu_en), .internal_pulldown_en(pd_en),
    .test_mode(test_mode), .tap_sel(tap_sel), .ir_value(ir_value));
  jtpc_tester i_jtpc_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic moves(input int n, input logic [7:0] m);
    logic q;
    for (int i = 0; i < n; i++) i_jtpc_tester.bit_step(m[i], 1'b1, q);
  endtask : moves
  // Shift n bits, leave through Update to Idle
  task automatic scan(input int n, input logic [63:0] d, output logic [63:0] o);
    logic q;
    o = '0;
    for (int i = 0; i < n; i++) begin
      i_jtpc_tester.bit_step(i == n - 1, d[i], q);
      o[i] = q;
    end
    moves(2, 8'h01);
  endtask : scan
  // Bypass stage delays the stream by one bit and captures zero first
  function automatic logic [7:0] bypass_exp(input logic [63:0] d);
    return {d[6:0], 1'b0};
  endfunction : bypass_exp
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    mismatches++;
    summarize();
  end
  initial begin
    {rst_b, e0_drv, e0_dir, e1_drv, e1_dir, sel_drv, evt_drv, pi} = '0;
    void'($urandom(32'h07A9));
    cyc(16);
    rst_b = 1'b1;
    cyc(4);
    repeat (4) begin
      pi = 5'($urandom);
      cyc(1);
      `CHK(pu_en, ~pi)
    end
    $display("test pulls done");
    evt_drv = 1'b1;
    moves(8, 8'hA5);
    `CHK(test_mode, 1'b0)
    `CHK(tdo_oe, 1'b0)
    `CHK(e1_ev, 1'b0)
    `CHK(pd_en, 1'b1)
    $display("test functional done");
    for (int v = 0; v < 2; v++) begin
      sel_drv = v[0];
      i_jtpc_tester.set_trst(1'b0);
      #250 i_jtpc_tester.set_trst(1'b1);
      cyc(6);
      `CHK(tap_sel, v[0])
      `CHK(test_mode, 1'b1)
    end
    $display("test select done");
    moves(5, 8'h1F);
    moves(4, 8'h02);
    din = {$urandom, $urandom};
    scan(64, din, dout);
    `CHK(dout[31:0], jtpc_pkg::ID_VALUE)
    `CHK(dout[63:32], din[31:0])
    cyc(6);
    `CHK(tdo_oe, 1'b0)
    moves(4, 8'h03);
    scan(4, {60'h0, jtpc_pkg::IR_BYPASS}, dout);
    `CHK(dout[3:0], jtpc_pkg::IR_CAPTURE)
    `CHK(ir_value, jtpc_pkg::IR_BYPASS)
    moves(3, 8'h01);
    scan(8, din, dout);
    `CHK(dout[7:0], bypass_exp(din))
    $display("test scan done");
    repeat (4) begin
      evt_drv = 1'($urandom);
      cyc(5);
      `CHK(e1_ev, evt_drv)
      `CHK(e0_ev, sel_drv)
    end
    e1_dir = 1'b1;
    e1_drv = ~evt_drv;
    cyc(1);
    `CHK(evt_wire, e1_drv)
    `CHK(e1_ev, 1'b0)
    e1_dir = 1'b0;
    e0_dir = 1'b1;
    e0_drv = ~sel_drv;
    cyc(5);
    `CHK(sel_wire, e0_drv)
    `CHK(e0_ev, 1'b0)
    e0_dir = 1'b0;
    $display("test events done");
    i_jtpc_tester.set_trst(1'b0);
    cyc(5);
    evt_drv = ~evt_drv;
    cyc(5);
    `CHK(ir_value, jtpc_pkg::IR_IDCODE)
    `CHK(tdo_oe, 1'b0)
    `CHK(e1_ev, 1'b0)
    $display("test test reset done");
    summarize();
  end
endmodule : jtpc_tb_top
